// ==== src/dacl_pkg.sv ====
// Shared constants and carrier types for the converter input latch control
package dacl_pkg;

  // Sample word width and code points
  localparam int unsigned          SAMPLE_W      = 12;
  localparam logic [SAMPLE_W-1:0]  CODE_ALL_ONES = 12'hFFF;
  localparam logic [SAMPLE_W-1:0]  CODE_MID      = 12'h800;
  localparam logic [SAMPLE_W-1:0]  CODE_ZERO     = 12'h000;

  // Field positions inside the sample word
  localparam int unsigned          BIT_LSB       = 0;
  localparam int unsigned          BIT_MSB       = SAMPLE_W - 1;

  // Buffer depth and pin synchroniser length
  localparam int unsigned          BUF_DEPTH     = 2;
  localparam int unsigned          SYNC_STAGES   = 2;

  // Sample clock period, 50 MHz
  localparam int unsigned          CLK_PERIOD_NS = 20;

  // Reset values
  localparam logic [SAMPLE_W-1:0]  RST_CODE      = 12'h000;
  localparam logic [1:0]           RST_SYNC      = 2'h0;

  // One sample word as carried through the latch
  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
  } dacl_sample_type;

  // Drive presented to the current steering array
  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
    logic [SAMPLE_W-1:0] true_weight;
    logic [SAMPLE_W-1:0] comp_weight;
  } dacl_array_type;

  // Operating state of the converter
  typedef enum logic [1:0] {
    DACL_ST_RUN  = 2'h1,
    DACL_ST_DOWN = 2'h2
  } dacl_state_type;

endpackage

// ==== src/dacl_buf.sv ====
// Two-entry valid/ready buffer that acts as the master stage of the latch
module dacl_buf (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Fill side
  input  wire logic                     i_valid,
  input  wire dacl_pkg::dacl_sample_type i_data,
  output logic                          o_ready,
  // Drain side
  output logic                          o_valid,
  output dacl_pkg::dacl_sample_type     o_data,
  input  wire logic                     i_ready
);

  dacl_pkg::dacl_sample_type mem_q [dacl_pkg::BUF_DEPTH];
  dacl_pkg::dacl_sample_type mem_d [dacl_pkg::BUF_DEPTH];
  logic                      wr_q;
  logic                      wr_d;
  logic                      rd_q;
  logic                      rd_d;
  logic [1:0]                cnt_q;
  logic [1:0]                cnt_d;
  logic                      push;
  logic                      pop;

  // Honest full and empty flags
  assign o_ready = (cnt_q != 2'(dacl_pkg::BUF_DEPTH));
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    unique case ({push, pop})
      2'b10:   cnt_d = cnt_q + 2'h1;
      2'b01:   cnt_d = cnt_q - 2'h1;
      default: cnt_d = cnt_q;
    endcase
  end

  // Register the buffer state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== src/dacl_top.sv ====
// Input latch, pipeline and static pin control of the 12-bit current converter
module dacl_top (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Sample source
  input  wire logic                          i_sample_valid,
  input  wire logic [dacl_pkg::SAMPLE_W-1:0] i_sample_bit,
  output logic                               o_sample_ready,
  // Static control pins
  input  wire logic                          i_power_down_pin,
  input  wire logic                          i_power_down_pin_driven,
  input  wire logic                          i_reference_select,
  // Current steering array
  input  wire logic                          i_array_ready,
  output logic                               o_array_valid,
  output dacl_pkg::dacl_array_type           o_array,
  // Power and reference status
  output logic                               o_power_down,
  output logic                               o_int_ref_en,
  output logic                               o_reference_voltage_pin_oe
);

  logic [1:0]                pd_sync_q;
  logic [1:0]                pd_sync_d;
  logic [1:0]                ref_sync_q;
  logic [1:0]                ref_sync_d;
  logic                      pd_level;
  dacl_pkg::dacl_state_type  state_q;
  dacl_pkg::dacl_state_type  state_d;
  dacl_pkg::dacl_sample_type in_word;
  dacl_pkg::dacl_sample_type head_word;
  logic                      head_valid;
  logic                      head_ready;
  dacl_pkg::dacl_array_type  arr_q;
  dacl_pkg::dacl_array_type  arr_d;
  logic                      arr_valid_q;
  logic                      arr_valid_d;
  logic                      int_ref_q;
  logic                      int_ref_d;

  // Pull-down makes a floating pin read as low
  assign pd_level = i_power_down_pin & i_power_down_pin_driven;

  // Two-stage synchronisers for the static pins
  always_comb begin
    pd_sync_d  = {pd_sync_q[0], pd_level};
    ref_sync_d = {ref_sync_q[0], i_reference_select};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_sync_q  <= dacl_pkg::RST_SYNC;
      ref_sync_q <= dacl_pkg::RST_SYNC;
    end else begin
      pd_sync_q  <= pd_sync_d;
      ref_sync_q <= ref_sync_d;
    end
  end

  // Operating state from the synchronised power-down level
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dacl_pkg::DACL_ST_RUN: begin
        if (pd_sync_q[1]) begin
          state_d = dacl_pkg::DACL_ST_DOWN;
        end
      end
      dacl_pkg::DACL_ST_DOWN: begin
        if (!pd_sync_q[1]) begin
          state_d = dacl_pkg::DACL_ST_RUN;
        end
      end
      default: state_d = dacl_pkg::DACL_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= dacl_pkg::DACL_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Master stage: whole word enters the buffer on each edge with valid and ready
  assign in_word.code = i_sample_bit;

  dacl_buf u_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (i_sample_valid),
    .i_data  (in_word),
    .o_ready (o_sample_ready),
    .o_valid (head_valid),
    .o_data  (head_word),
    .i_ready (head_ready)
  );

  // Slave stage loads when power is up and the array accepts or the slave is empty
  assign head_ready = (state_q == dacl_pkg::DACL_ST_RUN) & (i_array_ready | ~arr_valid_q);

  always_comb begin
    arr_d       = arr_q;
    arr_valid_d = arr_valid_q;
    if (state_q == dacl_pkg::DACL_ST_DOWN) begin
      arr_d.true_weight = dacl_pkg::CODE_ZERO;
      arr_d.comp_weight = dacl_pkg::CODE_ZERO;
      arr_valid_d       = 1'b0;
    end else if (head_ready) begin
      arr_valid_d = head_valid;
      if (head_valid) begin
        arr_d.code        = head_word.code;
        arr_d.true_weight = head_word.code;
        arr_d.comp_weight = dacl_pkg::CODE_ALL_ONES - head_word.code;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arr_q       <= '0;
      arr_valid_q <= 1'b0;
    end else begin
      arr_q       <= arr_d;
      arr_valid_q <= arr_valid_d;
    end
  end

  // Reference source from the synchronised select level
  always_comb begin
    int_ref_d = ~ref_sync_q[1];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_ref_q <= 1'b0;
    end else begin
      int_ref_q <= int_ref_d;
    end
  end

  // Outputs
  assign o_array                    = arr_q;
  assign o_array_valid              = arr_valid_q;
  assign o_power_down               = (state_q == dacl_pkg::DACL_ST_DOWN);
  assign o_int_ref_en               = int_ref_q;
  assign o_reference_voltage_pin_oe = int_ref_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Helpers for the checks
  logic                                push_seen;
  logic [dacl_pkg::SAMPLE_W-1:0]       push_code;
  assign push_seen = i_sample_valid & o_sample_ready;
  assign push_code = i_sample_bit;

  capture_taken_a: assert property (
    (i_sample_valid && o_sample_ready) |=> (u_buf.cnt_q != 2'h0))
    else $error("Offered sample was not captured");

  pipe_latency_a: assert property (
    (push_seen && !head_valid && state_q == dacl_pkg::DACL_ST_RUN && !pd_sync_q[1]
     && (i_array_ready || !arr_valid_q))
    |=> ##1 (o_array.code == $past(push_code, 2) && o_array_valid))
    else $error("Sample did not reach array one edge after capture");

  binary_weight_a: assert property (
    o_array_valid |-> (o_array.true_weight == o_array.code))
    else $error("True weight is not the straight binary code");

  steer_sum_a: assert property (
    o_array_valid |-> (o_array.true_weight + o_array.comp_weight
                       == dacl_pkg::CODE_ALL_ONES))
    else $error("Steered currents do not add to full scale");

  full_scale_a: assert property (
    (o_array_valid && o_array.code == dacl_pkg::CODE_ALL_ONES)
    |-> (o_array.comp_weight == dacl_pkg::CODE_ZERO))
    else $error("All ones code leaks to complement output");

  zero_scale_a: assert property (
    (o_array_valid && o_array.code == dacl_pkg::CODE_ZERO)
    |-> (o_array.true_weight == dacl_pkg::CODE_ZERO))
    else $error("All zeros code leaks to true output");

  mid_scale_a: assert property (
    (o_array_valid && o_array.code == dacl_pkg::CODE_MID)
    |-> (o_array.true_weight == dacl_pkg::CODE_MID))
    else $error("Mid code does not split the current");

  pd_entry_a: assert property (
    $rose(pd_level) |-> ##3 o_power_down)
    else $error("Power-down not entered three edges after pin rise");

  pd_quiet_a: assert property (
    o_power_down |=> (!o_array_valid && o_array.true_weight == dacl_pkg::CODE_ZERO))
    else $error("Array still driven in power-down");

  float_run_a: assert property (
    (!i_power_down_pin_driven)[*4] |-> !o_power_down)
    else $error("Floating power-down pin stopped conversion");

  int_ref_a: assert property (
    (!i_reference_select)[*4] |-> (o_int_ref_en && o_reference_voltage_pin_oe))
    else $error("Grounded select did not enable internal reference");

  ext_ref_a: assert property (
    (i_reference_select)[*4] |-> (!o_int_ref_en && !o_reference_voltage_pin_oe))
    else $error("High select left internal reference driving pin");

endmodule

// ==== verification/dacl_src.sv ====
// Sample source model offering words by valid/ready, scripted or random
module dacl_src (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Random traffic enable
  input  wire logic                          i_en,
  // Handshake to the latch
  input  wire logic                          i_ready,
  output logic                               o_valid,
  output logic [dacl_pkg::SAMPLE_W-1:0]      o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [dacl_pkg::SAMPLE_W-1:0] plan_q[$];
  logic [dacl_pkg::SAMPLE_W-1:0] exp_q[$];
  integer                        seed = 32'h2137;
  // Note taken words, then offer scripted, random or nothing
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_word  <= 12'hA5A;
    end else begin
      if (o_valid && i_ready) exp_q.push_back(o_word);
      if (!o_valid || i_ready) begin
        if (plan_q.size() > 0) begin
          o_valid <= 1'b1;
          o_word  <= plan_q.pop_front();
        end else if (i_en && ($random(seed) % 4 != 0)) begin
          o_valid <= 1'b1;
          o_word  <= 12'($random(seed));
        end else begin
          o_valid <= 1'b0;
          o_word  <= ~o_word; // Idle bus inverts the word on every idle cycle
        end
      end
    end
  end
endmodule

// ==== verification/dacl_top_test.sv ====
// Self-checking testbench for the converter input latch control
module dacl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst, src_en, pd_pin, pd_drv, ref_sel;
  logic                     arr_rdy, rnd_rdy, stall, lat_q, lat2_q;
  logic                     s_valid, s_ready, a_valid, pwr_dn, ref_en, ref_oe;
  logic [11:0]              s_word, exp_w;
  dacl_pkg::dacl_array_type arr;
  integer                   fail_count = 0, comparisons = 0, cycles = 0;
  integer                   seed = 32'h2137;

  // Sample clock, even duty
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  dacl_src u_src (.i_clk(clk), .i_rst(rst), .i_en(src_en), .i_ready(s_ready),
                  .o_valid(s_valid), .o_word(s_word));

  dacl_top DUT (.i_clk(clk), .i_rst(rst), .i_sample_valid(s_valid), .i_sample_bit(s_word),
                .o_sample_ready(s_ready), .i_power_down_pin(pd_pin),
                .i_power_down_pin_driven(pd_drv), .i_reference_select(ref_sel),
                .i_array_ready(arr_rdy), .o_array_valid(a_valid), .o_array(arr),
                .o_power_down(pwr_dn), .o_int_ref_en(ref_en),
                .o_reference_voltage_pin_oe(ref_oe));

  task automatic check_code(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Wait until every offered word has reached the array
  task automatic drain;
    for (int i = 0; i < 200; i++) begin
      if (u_src.exp_q.size() == 0 && u_src.plan_q.size() == 0 && !s_valid && !a_valid) break;
      tick(1);
    end
    check_bit("all delivered", 1'b1, u_src.exp_q.size() == 0);
  endtask

  // Array ready, held or random
  always @(posedge clk) arr_rdy <= rnd_rdy ? 1'($random(seed)) : !stall;

  // Compare accepted array words with the oldest noted sample
  always @(posedge clk) begin
    if (!rst && a_valid && arr_rdy && !pwr_dn) begin
      if (u_src.exp_q.size() == 0) check_bit("spare word", 1'b0, 1'b1);
      else begin
        exp_w = u_src.exp_q.pop_front();
        check_code("code", exp_w, arr.code);
        check_code("true weight", exp_w, arr.true_weight);
        check_code("comp weight", 12'hFFF - exp_w, arr.comp_weight);
      end
    end
    // Word taken at one edge is loaded at the next and seen valid after it
    if (lat2_q) check_bit("latency", 1'b1, a_valid);
    lat2_q <= lat_q;
    lat_q <= !rst && s_valid && s_ready && !a_valid && !pwr_dn && !pd_pin;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    src_en = 1'b0;
    pd_pin = 1'b0;
    pd_drv = 1'b1;
    ref_sel = 1'b0;
    rnd_rdy = 1'b0;
    stall = 1'b0;
    arr_rdy = 1'b1;
    lat_q = 1'b0;
    lat2_q = 1'b0;
    tick(2);
    rst <= 1'b0;
    tick(5);
    check_bit("sample ready", 1'b1, s_ready);
    check_bit("power down", 1'b0, pwr_dn);
    check_bit("internal ref", 1'b1, ref_en);
    check_bit("ref pin drive", 1'b1, ref_oe);
    // Code points back to back
    u_src.plan_q = '{12'hFFF, 12'h800, 12'h000, 12'h001};
    drain();
    // Stalled array, buffer fills and refuses
    stall <= 1'b1;
    src_en <= 1'b1;
    tick(14);
    check_bit("ready when full", 1'b0, s_ready);
    // Random stream with random stalls
    rnd_rdy <= 1'b1;
    tick(800);
    rnd_rdy <= 1'b0;
    stall <= 1'b0;
    src_en <= 1'b0;
    drain();
    // Power-down pin high, then left open
    pd_pin <= 1'b1;
    tick(3);
    check_bit("power down", 1'b1, pwr_dn);
    check_bit("array valid", 1'b0, a_valid);
    pd_drv <= 1'b0;
    tick(3);
    check_bit("open pin runs", 1'b0, pwr_dn);
    // External reference
    ref_sel <= 1'b1;
    tick(3);
    check_bit("internal ref", 1'b0, ref_en);
    check_bit("ref pin drive", 1'b0, ref_oe);
    tick(2);
    // Back to the internal reference
    ref_sel <= 1'b0;
    tick(3);
    check_bit("internal ref", 1'b1, ref_en);
    check_bit("ref pin drive", 1'b1, ref_oe);
    tick(2);
    wrap_up();
  end
endmodule
